/* core/csr_reporter.sv */
// status line reporter: strobe detection and pulse-count reply
`timescale 1ns/1ps
module csr_reporter #(
	parameter int unsigned RPT_DELAY = csr_pkg::RPT_DELAY_CYC,
	parameter int unsigned PERIOD = csr_pkg::PERIOD_CYC,
	parameter int unsigned MAX_STROBE = csr_pkg::MAX_STROBE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire csr_pkg::csr_status_s status_i,
	input wire logic line_i,
	output logic line_o,
	output logic line_oe_o,
	output logic busy_o
);
	localparam logic [csr_pkg::CW-1:0] DLY = csr_pkg::CW'(RPT_DELAY);
	localparam logic [csr_pkg::CW-1:0] PER = csr_pkg::CW'(PERIOD);
	localparam logic [csr_pkg::CW-1:0] HALF = csr_pkg::CW'(PERIOD / 2);
	localparam logic [csr_pkg::CW-1:0] MAXS = csr_pkg::CW'(MAX_STROBE);
	localparam logic [csr_pkg::CW-1:0] MINS = csr_pkg::CW'(csr_pkg::REQ_LOW_CYC);

	typedef struct packed {
		csr_pkg::csr_state_e st;
		logic [csr_pkg::CW-1:0] tmr;
		logic [4:0] left;
		logic [4:0] sent;
		logic oe;
		logic busy;
	} csr_rep_s;

	csr_rep_s r, next_r;
	logic line_s;
	logic [4:0] code;

	csr_sync u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(line_i),
		.q_o(line_s)
	);

	// faults take priority over charge phases; a bad phase reports an error
	always_comb begin
		code = csr_pkg::CNT_ERROR; // RULE3
		if (status_i.die_hot) begin
			code = csr_pkg::CNT_DIE_HOT; // RULE3
		end else if (status_i.bat_temp_fault) begin
			code = csr_pkg::CNT_BAT_TEMP; // RULE3
		end else if (status_i.over_voltage) begin
			code = csr_pkg::CNT_OVP; // RULE3
		end else if (status_i.phase <= csr_pkg::PHASE_LAST) begin
			if (status_i.high_rate_setting) begin
				code = csr_pkg::CNT_HIGH_BASE + 5'(status_i.phase); // RULE4
			end else begin
				code = csr_pkg::CNT_LOW_BASE + 5'(status_i.phase); // RULE5
			end
		end
	end

	always_comb begin
		next_r = r;
		case (r.st)
			csr_pkg::CSR_IDLE: begin
				next_r.oe = 1'b0;
				next_r.busy = 1'b0;
				if (!line_s) begin
					next_r.st = csr_pkg::CSR_STROBE; // RULE1
					next_r.tmr = '0;
				end
			end
			csr_pkg::CSR_STROBE: begin
				// a low too short to be a strobe is dropped; two cycles of slack absorb pin jitter
				// a long low saturates the timer and still counts, so a slow pull-up is tolerated
				if (line_s) begin
					if (r.tmr >= MINS - 16'h0002) begin
						next_r.st = csr_pkg::CSR_DELAY; // RULE7
						next_r.tmr = '0;
						next_r.left = code;
						next_r.sent = '0;
						next_r.busy = 1'b1;
					end else begin
						next_r.st = csr_pkg::CSR_IDLE;
					end
				end else if (r.tmr < MAXS) begin
					next_r.tmr = r.tmr + 16'h0001;
				end
			end
			csr_pkg::CSR_DELAY: begin
				next_r.tmr = r.tmr + 16'h0001;
				if (r.tmr == DLY - 16'h0001) begin
					next_r.st = csr_pkg::CSR_BURST; // RULE7
					next_r.tmr = '0;
					next_r.oe = 1'b1; // RULE2
				end
			end
			csr_pkg::CSR_BURST: begin
				next_r.tmr = r.tmr + 16'h0001;
				if (r.tmr == HALF - 16'h0001) begin
					next_r.oe = 1'b0; // RULE2
					next_r.sent = r.sent + 5'h01;
					next_r.left = r.left - 5'h01;
				end
				if (r.tmr == PER - 16'h0001) begin
					next_r.tmr = '0; // RULE8
					if (r.left == 5'h00) begin
						next_r.st = csr_pkg::CSR_IDLE;
						next_r.busy = 1'b0;
					end else begin
						next_r.oe = 1'b1; // RULE8
					end
				end
			end
			default: begin
				next_r.st = csr_pkg::CSR_IDLE;
				next_r.oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r <= '{st: csr_pkg::CSR_IDLE, tmr: '0, left: '0, sent: '0, oe: 1'b0, busy: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign line_o = 1'b0;
	assign line_oe_o = r.oe;
	assign busy_o = r.busy;

	sequence s_strobe_end;
		r.st == csr_pkg::CSR_STROBE && line_s && r.tmr >= MINS - 16'h0002;
	endsequence
	sequence s_quiet;
		!r.oe [*2];
	endsequence

	AST_NO_EARLY_DRIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
		s_strobe_end |=> s_quiet) else $error("line driven before report delay");
	AST_DELAY_EXACT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
		$rose(r.st == csr_pkg::CSR_DELAY) |-> !r.oe [*1] ##0 (r.tmr == '0))
		else $error("delay timer not cleared");
	AST_FIRST_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
		(r.st == csr_pkg::CSR_DELAY && r.tmr == DLY - 16'h0001) |=> r.oe)
		else $error("first pulse missing after delay");
	AST_PERIOD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
		(r.st == csr_pkg::CSR_BURST && $rose(r.oe)) |-> r.tmr == '0)
		else $error("pulse not aligned to period");
	AST_HALF_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
		(r.st == csr_pkg::CSR_BURST && r.tmr == HALF - 16'h0001 && r.oe) |=> !r.oe)
		else $error("pulse low time wrong");
	AST_COUNT_MATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
		(r.st == csr_pkg::CSR_BURST && r.tmr == PER - 16'h0001 && r.left == 5'h00)
		|=> r.st == csr_pkg::CSR_IDLE && !r.oe) else $error("burst ended badly");
	AST_NO_UNUSED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
		$rose(r.st == csr_pkg::CSR_DELAY) |-> (r.left < 5'h04 || r.left > 5'h0c) && r.left != 5'h00)
		else $error("unused count loaded");
	AST_HIGH_MAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE4
		(!status_i.die_hot && !status_i.bat_temp_fault && !status_i.over_voltage
		&& status_i.high_rate_setting && status_i.phase <= csr_pkg::PHASE_LAST)
		|-> code >= csr_pkg::CNT_HIGH_BASE && code < csr_pkg::CNT_LOW_BASE)
		else $error("high-rate code out of range");
	AST_LOW_MAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
		(!status_i.die_hot && !status_i.bat_temp_fault && !status_i.over_voltage
		&& !status_i.high_rate_setting && status_i.phase <= csr_pkg::PHASE_LAST)
		|-> code >= csr_pkg::CNT_LOW_BASE && code < csr_pkg::CNT_ERROR)
		else $error("low-rate code out of range");
	AST_IDLE_RELEASE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
		r.st == csr_pkg::CSR_IDLE |=> !r.oe) else $error("line held while idle");

	// one reply period: the pulse opens at timer zero and closes at half period
	sequence s_burst_start;
		r.st == csr_pkg::CSR_BURST && r.tmr == '0 && r.oe;
	endsequence
	sequence s_pulse_fall;
		r.st == csr_pkg::CSR_BURST && r.tmr == HALF - 16'h0001;
	endsequence

	AST_IDLE_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
		(r.st == csr_pkg::CSR_IDLE && !line_s) |=> r.st == csr_pkg::CSR_STROBE && r.tmr == '0)
		else $error("strobe start missed");
	AST_IDLE_FREE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
		r.st == csr_pkg::CSR_IDLE |-> !r.busy)
		else $error("busy while idle");
	AST_ACCEPT_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
		s_strobe_end |=> r.st == csr_pkg::CSR_DELAY && r.busy && r.left == $past(code))
		else $error("reply not armed on strobe end");
	AST_SHORT_DROP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
		(r.st == csr_pkg::CSR_STROBE && line_s && r.tmr < MINS - 16'h0002)
		|=> r.st == csr_pkg::CSR_IDLE && !r.busy) else $error("short strobe answered");
	AST_STROBE_SAT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
		r.st == csr_pkg::CSR_STROBE |-> r.tmr <= MAXS)
		else $error("strobe timer ran past its ceiling");
	AST_DELAY_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
		r.st == csr_pkg::CSR_DELAY |-> !r.oe && r.busy && r.tmr < DLY)
		else $error("line driven during report delay");
	AST_BURST_START: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
		(r.st == csr_pkg::CSR_DELAY && r.tmr == DLY - 16'h0001) |=> s_burst_start)
		else $error("burst did not open with a pulse");
	AST_BURST_TMR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
		r.st == csr_pkg::CSR_BURST |-> r.tmr < PER && r.busy)
		else $error("period timer out of range");
	AST_PULSE_RISE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
		(r.st == csr_pkg::CSR_BURST && r.tmr == PER - 16'h0001 && r.left != 5'h00)
		|=> s_burst_start) else $error("next pulse not at period end");
	AST_SENT_STEP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
		s_pulse_fall |=> !r.oe && r.sent == $past(r.sent) + 5'h01)
		else $error("pulse not counted");
	AST_SENT_TOTAL: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
		r.st == csr_pkg::CSR_BURST |-> $stable(r.sent + r.left))
		else $error("pulse total drifted in burst");
	AST_SENT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
		$rose(r.st == csr_pkg::CSR_DELAY) |-> r.sent == 5'h00)
		else $error("pulse tally not cleared");
	AST_OE_BURST: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
		r.oe |-> r.st == csr_pkg::CSR_BURST)
		else $error("line pulled outside a burst");
	AST_CODE_FAULT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
		status_i.die_hot |-> code == csr_pkg::CNT_DIE_HOT)
		else $error("die fault not reported first");
	AST_CODE_ERROR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
		(!status_i.die_hot && !status_i.bat_temp_fault && !status_i.over_voltage
		&& status_i.phase > csr_pkg::PHASE_LAST) |-> code == csr_pkg::CNT_ERROR)
		else $error("bad phase not reported as error");
endmodule : csr_reporter

/* core/csr_pkg.sv */
// shared constants and types of the charge status pulse reporter
// Operation
// RULE1: one shared line: host sends a request strobe, device answers with pulses.
// RULE2: line is active low, idles high by pull-up; parties only pull low.
// RULE3: count 1 die hot, 2 battery temp fault, 3 over-voltage, 23 error; 4-12 unused.
// RULE4: high-rate setting reports 13..17 for the five charge phases in order.
// RULE5: low-rate setting reports 18..22 for the same five phases in order.
// RULE6: host drives line low at least 200ns, then releases it.
// RULE7: device waits for strobe rising edge, then the report delay, then replies.
// RULE8: reply pulses are spaced at the pulse period throughout the burst.
// RULE9: host keeps strobe low below the maximum pulse time or reports may be false.
// RULE10: host counts pulses; long high time ends burst; count maps to status.
package csr_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned CLK_PS = 25000;
	localparam int unsigned REQ_LOW_NS = 200;
	localparam int unsigned REQ_LOW_CYC = (REQ_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned RPT_DELAY_NS = 10000;
	localparam int unsigned PULSE_PERIOD_NS = 10000;
	localparam int unsigned MAX_STROBE_NS = 20000;
	localparam int unsigned RPT_DELAY_CYC = (RPT_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned PERIOD_CYC = (PULSE_PERIOD_NS * 1000) / CLK_PS;
	localparam int unsigned MAX_STROBE_CYC = (MAX_STROBE_NS * 1000) / CLK_PS;
	localparam int CW = 16;
	localparam logic [4:0] CNT_DIE_HOT = 5'h01;
	localparam logic [4:0] CNT_BAT_TEMP = 5'h02;
	localparam logic [4:0] CNT_OVP = 5'h03;
	localparam logic [4:0] CNT_HIGH_BASE = 5'h0d;
	localparam logic [4:0] CNT_LOW_BASE = 5'h12;
	localparam logic [4:0] CNT_ERROR = 5'h17;
	localparam logic [2:0] PHASE_LAST = 3'h4;
	typedef enum logic [3:0] {
		CSR_IDLE = 4'h1,
		CSR_STROBE = 4'h2,
		CSR_DELAY = 4'h4,
		CSR_BURST = 4'h8
	} csr_state_e;
	typedef struct packed {
		logic die_hot;
		logic bat_temp_fault;
		logic over_voltage;
		logic high_rate_setting;
		logic [2:0] phase;
	} csr_status_s;
	typedef struct packed {
		logic [2:0] sync;
		logic level;
	} csr_sync_s;
endpackage : csr_pkg

/* core/csr_sync.sv */
// three-flop line synchroniser with agreement filter
`timescale 1ns/1ps
module csr_sync (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic d_i,
	output logic q_o
);
	csr_pkg::csr_sync_s r, next_r;
	always_comb begin
		next_r = r;
		next_r.sync = {r.sync[1:0], d_i};
		// first flop feeds only the second; stages two and three must agree
		if (r.sync[2] == r.sync[1]) begin
			next_r.level = r.sync[2];
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r <= {3'h7, 1'b1};
		end else begin
			r <= next_r;
		end
	end
	assign q_o = r.level;
endmodule : csr_sync

/* sim/csr_host.sv */
// microcontroller pin model: request strobe and pulse counter
`timescale 1ns/1ps
module csr_host #(
	parameter int IDLE_CYC = 24
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic go_i,
	input wire logic [7:0] len_i,
	input wire logic line_i,
	output logic pull_o,
	output logic done_o,
	output logic [4:0] count_o
);
	int t;
	int idle;
	logic prev;
	logic seen;
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		prev <= line_i;
		if (!rst_n_i) begin
			pull_o <= 1'b0;
			t <= 0;
			count_o <= 5'h00;
			seen <= 1'b0;
			idle <= 0;
		end else if (go_i && t == 0) begin
			pull_o <= 1'b1;
			t <= int'(len_i);
			count_o <= 5'h00;
			seen <= 1'b0;
		end else if (t > 1) begin
			t <= t - 1;
		end else if (t == 1) begin
			pull_o <= 1'b0;
			t <= 0;
		end else if (prev && !line_i) begin
			count_o <= count_o + 5'h01;
			seen <= 1'b1;
			idle <= 0;
		end else if (line_i && seen) begin
			idle <= idle + 1;
			// long high time closes the burst
			if (idle == IDLE_CYC) begin
				done_o <= 1'b1;
				seen <= 1'b0;
			end
		end
	end
endmodule : csr_host

/* sim/test_charge_status_pulse_reporter.sv */
// self-checking bench of the status line reporter
`timescale 1ns/1ps
module test_charge_status_pulse_reporter;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic go = 1'b0;
	logic [7:0] len = 8'h0a;
	csr_pkg::csr_status_s status_i = '0;
	logic line_o, line_oe_o, busy_o, pull, done, poe;
	logic [4:0] count;
	logic [4:0] expq[$];
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	int gap = 0;
	int seed = 32'hc164;
	int rel = 0;
	localparam int DLY = 10;
	// pull-up wins unless a party pulls low
	wire line = !(line_oe_o && !line_o) && !pull;
	always #12.5 clk_i = ~clk_i;
	csr_reporter #(.RPT_DELAY(DLY), .PERIOD(8), .MAX_STROBE(20)) u_csr_reporter (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .status_i(status_i), .line_i(line), .line_o(line_o),
		.line_oe_o(line_oe_o), .busy_o(busy_o));
	csr_host #(.IDLE_CYC(24)) u_csr_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go),
		.len_i(len), .line_i(line), .pull_o(pull), .done_o(done), .count_o(count));
	function automatic logic [4:0] exp_cnt(input csr_pkg::csr_status_s s);
		if (s.die_hot) return 5'h01;
		if (s.bat_temp_fault) return 5'h02;
		if (s.over_voltage) return 5'h03;
		if (s.phase > 3'h4) return 5'h17;
		return (s.high_rate_setting ? 5'h0d : 5'h12) + {2'h0, s.phase};
	endfunction : exp_cnt
	task check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task test_done;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	task query(input logic [6:0] s, input logic [7:0] l);
		@(negedge clk_i);
		status_i = s;
		len = l;
		go = 1'b1;
		if (l > 8'h08) expq.push_back(exp_cnt(s));
		@(negedge clk_i);
		go = 1'b0;
		repeat (40) @(negedge clk_i);
		while (busy_o !== 1'b0 || line !== 1'b1) @(negedge clk_i);
		repeat (30) @(negedge clk_i);
		check({7'h00, busy_o}, 8'h00);
	endtask : query
	always @(posedge clk_i) begin
		cycles++;
		if (done && expq.size() == 0) check({3'h0, count}, 8'h00);
		else if (done) check({3'h0, count}, {3'h0, expq.pop_front()});
		poe <= line_oe_o;
		// cycles since the strobe was released, to time the report delay
		if (pull) rel <= 1;
		else if (rel > 0) rel <= rel + 1;
		// the first pulse of every burst has no gap yet and is timed against the strobe release
		if (line_oe_o && !poe) begin
			if (gap > 0) check(gap[7:0], 8'h08);
			else check({7'h00, (rel > DLY) && (rel <= DLY + 8)}, 8'h01);
			gap <= 1;
		end else if (!busy_o) gap <= 0;
		else if (gap > 0) gap <= gap + 1;
		if (cycles == 20000) begin
			fails++;
			test_done();
		end
	end
	initial begin
		repeat (10) @(negedge clk_i);
		rst_n_i = 1'b1;
		query(7'h7f, 8'h0a);
		query(7'h30, 8'h0a);
		query(7'h1c, 8'h0a);
		for (int i = 0; i < 16; i++) query({3'h0, i[3:0]}, 8'h0a);
		query(7'h0d, 8'h03);
		query(7'h0a, 8'h14);
		for (int i = 0; i < 6; i++) query(7'($random(seed)), 8'h0a);
		check({3'h0, 5'(expq.size())}, 8'h00);
		test_done();
	end
endmodule : test_charge_status_pulse_reporter
